// ### verilog/clock_monitor_pkg.sv
// shared constants, types and register map for the reference clock monitor
package clock_monitor_pkg;

  // register byte addresses
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;

  // control register field positions
  localparam int MODE_LSB   = 0;
  localparam int POLICY_LSB = 2;
  localparam int SEL_BIT    = 4;

  // operating mode codes
  localparam logic [1:0] MODE_SYNTH = 2'h0;
  localparam logic [1:0] MODE_HBW   = 2'h1;
  localparam logic [1:0] MODE_LBW   = 2'h2;

  // reset values
  localparam logic [1:0] MODE_RESET   = 2'h2;
  localparam logic [1:0] POLICY_RESET = 2'h0;
  localparam logic       SEL_RESET    = 1'b0;

  // feedback edges without a monitored edge before an input is declared missing
  localparam logic [1:0] MISS_EDGES = 2'h3;

  // phase slope limiting: one period stretch per step time
  localparam int CLK_PERIOD_NS = 25;
  localparam int PSL_STEP_NS   = 200;
  localparam int PSL_STEP_CYC  = (PSL_STEP_NS / CLK_PERIOD_NS < 1) ? 1 : PSL_STEP_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic xtal;
    logic ref0;
    logic ref1;
    logic upper_fb;
    logic lower_fb;
  } edge_s;

  typedef struct packed {
    logic       clk_sel;
    logic [1:0] policy;
    logic [1:0] mode;
  } ctrl_s;

  typedef enum logic [3:0] {
    ST_SYNTH   = 4'b0001,
    ST_ACQUIRE = 4'b0010,
    ST_TRACK   = 4'b0100,
    ST_HOLD    = 4'b1000
  } sel_state_e;

endpackage

// ### verilog/ref_clock_monitor_switchover.sv
// reference clock monitor, alarm generation and reference switchover with apb registers
//
// Behaviour
// - crystal missing alarm after three upper feedback edges without a crystal edge
// - crystal missing alarm clears at once on any crystal edge
// - reference 0 missing alarm after three feedback edges without a reference 0 edge
// - references compare to upper feedback in high bandwidth, lower in low bandwidth
// - reference 0 missing alarm clears once a reference 0 edge is seen
// - reference 1 missing alarm works like reference 0 on its own input
// - lock flag only after frequency lock, drops as soon as lock is lost
// - active reference output shows which input drives the output
// - holdover alarm when no valid reference is in use
// - synthesizer mode uses no reference and does no selection or switching
// - two-bit policy field picks pin manual, register manual, revertive, non-revertive
// - manual policies switch only when the user changes pin or register select
// - manual: selected input bad enters holdover or free-run with alarm
// - manual: leave holdover once the selected input is valid again
// - automatic policies take preference from register select only, pin ignored
// - automatic: unlocked start locks to preferred input, ignores the other
// - automatic locked: stay on preferred, fail over if other valid, else holdover
// - automatic recovery picks preferred when both inputs valid
// - automatic recovery takes whichever input is valid first
// - on non-preferred input: revertive returns to preferred, non-revertive stays
// - after a switch phase is realigned at fixed rate by stretching periods only
// - no phase adjustment while in holdover or free-run
// - two-bit mode field selects synthesizer, high or low bandwidth translation
`timescale 1ns/100ps

module ref_clock_monitor_switchover
#(
  parameter logic [1:0] POLICY_PIN_CODE    = 2'h0,
  parameter logic [1:0] POLICY_REG_CODE    = 2'h1,
  parameter logic [1:0] POLICY_REVERT_CODE = 2'h2,
  parameter int         PHASE_W            = 8
)
(
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic [31:0]                        prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire clock_monitor_pkg::edge_s      edges,
  input  wire logic                          clk_sel_pin,
  input  wire logic                          freq_lock,
  input  wire logic [PHASE_W-1:0]            phase_diff,
  output logic                               crystal_missing_alarm,
  output logic                               ref0_missing_alarm,
  output logic                               ref1_missing_alarm,
  output logic                               pll_locked_flag,
  output logic                               active_ref,
  output logic                               holdover_alarm,
  output logic                               free_run_flag,
  output logic                               stretch_pulse
);
  import clock_monitor_pkg::*;

  ctrl_s              ctrl;
  sel_state_e         state;
  sel_state_e         next_state;
  logic [1:0]         xtal_cnt;
  logic [1:0]         ref0_cnt;
  logic [1:0]         ref1_cnt;
  logic [1:0]         next_xtal_cnt;
  logic [1:0]         next_ref0_cnt;
  logic [1:0]         next_ref1_cnt;
  logic               ref_fb;
  logic               sel_now;
  logic               next_active;
  logic               ref0_ok;
  logic               ref1_ok;
  logic               policy_manual;
  logic               policy_revert;
  logic               switch_event;
  logic [PHASE_W-1:0] phase_left;
  logic [7:0]         step_cnt;
  logic               setup;

  // count feedback edges since the last monitored edge, saturating at the limit
  function automatic logic [1:0] miss_step(input logic [1:0] cnt, input logic mon_edge, input logic fb_edge);
    if (mon_edge)
      miss_step = 2'h0;
    else if (fb_edge && cnt != MISS_EDGES)
      miss_step = cnt + 2'h1;
    else
      miss_step = cnt;
  endfunction

  // validity of the input that a select value points at
  function automatic logic ref_valid(input logic sel, input logic ok0, input logic ok1);
    ref_valid = sel ? ok1 : ok0;
  endfunction

  assign ref_fb        = (ctrl.mode == MODE_LBW) ? edges.lower_fb : edges.upper_fb;
  assign next_xtal_cnt = miss_step(xtal_cnt, edges.xtal, edges.upper_fb);
  assign next_ref0_cnt = miss_step(ref0_cnt, edges.ref0, ref_fb);
  assign next_ref1_cnt = miss_step(ref1_cnt, edges.ref1, ref_fb);
  assign ref0_ok       = (next_ref0_cnt != MISS_EDGES);
  assign ref1_ok       = (next_ref1_cnt != MISS_EDGES);
  assign policy_manual = (ctrl.policy == POLICY_PIN_CODE) || (ctrl.policy == POLICY_REG_CODE);
  assign policy_revert = (ctrl.policy == POLICY_REVERT_CODE);
  // pin used only in manual via pin; automatic takes register preference
  assign sel_now       = (ctrl.policy == POLICY_PIN_CODE) ? clk_sel_pin : ctrl.clk_sel;
  assign setup         = psel && !penable;

  // missing-edge counters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xtal_cnt <= 2'h0;
      ref0_cnt <= 2'h0;
      ref1_cnt <= 2'h0;
    end
    else
    begin
      xtal_cnt <= next_xtal_cnt;
      ref0_cnt <= next_ref0_cnt;
      ref1_cnt <= next_ref1_cnt;
    end
  end

  // alarm pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      crystal_missing_alarm <= 1'b0;
      ref0_missing_alarm    <= 1'b0;
      ref1_missing_alarm    <= 1'b0;
    end
    else
    begin
      crystal_missing_alarm <= (next_xtal_cnt == MISS_EDGES);
      ref0_missing_alarm    <= !ref0_ok;
      ref1_missing_alarm    <= !ref1_ok;
    end
  end

  // reference selection
  always_comb
  begin
    next_state  = state;
    next_active = active_ref;
    case (state)
      ST_SYNTH:
      begin
        if (ctrl.mode == MODE_HBW || ctrl.mode == MODE_LBW)
        begin
          next_state  = ST_ACQUIRE;
          next_active = sel_now;
        end
      end
      ST_ACQUIRE:
      begin
        // until locked only the selected input counts, to avoid hunting
        next_active = sel_now;
        if (policy_manual && !ref_valid(sel_now, ref0_ok, ref1_ok))
          next_state = ST_HOLD;
        else if (!policy_manual && !ref0_ok && !ref1_ok)
          next_state = ST_HOLD;
        else if (freq_lock && ref_valid(sel_now, ref0_ok, ref1_ok))
          next_state = ST_TRACK;
      end
      ST_TRACK:
      begin
        if (policy_manual)
        begin
          next_active = sel_now;
          if (!ref_valid(sel_now, ref0_ok, ref1_ok))
            next_state = ST_HOLD;
        end
        else if (!ref_valid(active_ref, ref0_ok, ref1_ok))
        begin
          if (ref_valid(!active_ref, ref0_ok, ref1_ok))
            next_active = !active_ref;
          else
            next_state = ST_HOLD;
        end
        else if (policy_revert && active_ref != sel_now && ref_valid(sel_now, ref0_ok, ref1_ok))
          next_active = sel_now;
      end
      ST_HOLD:
      begin
        if (policy_manual)
        begin
          next_active = sel_now;
          if (ref_valid(sel_now, ref0_ok, ref1_ok))
            next_state = ST_TRACK;
        end
        // automatic recovery: preference only matters when both inputs are valid
        else if (ref0_ok && ref1_ok)
        begin
          next_active = sel_now;
          next_state  = ST_TRACK;
        end
        else if (ref0_ok || ref1_ok)
        begin
          next_active = ref1_ok;
          next_state  = ST_TRACK;
        end
      end
      default:
        next_state = ST_SYNTH;
    endcase
    // synthesizer mode and the unused code stop all selection
    if (ctrl.mode != MODE_HBW && ctrl.mode != MODE_LBW)
    begin
      next_state  = ST_SYNTH;
      next_active = active_ref;
    end
  end

  // a change of input or a recovery from holdover starts a phase realignment
  assign switch_event = (next_active != active_ref) || (state == ST_HOLD && next_state == ST_TRACK);

  // selection state and active input
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state      <= ST_SYNTH;
      active_ref <= SEL_RESET;
    end
    else
    begin
      state      <= next_state;
      active_ref <= next_active;
    end
  end

  // status pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      holdover_alarm  <= 1'b0;
      free_run_flag   <= 1'b0;
      pll_locked_flag <= 1'b0;
    end
    else
    begin
      holdover_alarm  <= (next_state == ST_HOLD);
      free_run_flag   <= (next_state == ST_HOLD) && (ctrl.mode == MODE_HBW);
      pll_locked_flag <= freq_lock && (next_state != ST_HOLD);
    end
  end

  // phase slope limiting: one stretched period per step until phase realigned
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_left    <= '0;
      step_cnt      <= 8'h00;
      stretch_pulse <= 1'b0;
    end
    else
    begin
      stretch_pulse <= 1'b0;
      if (next_state == ST_HOLD || next_state == ST_SYNTH)
      begin
        // no realignment may run while no reference is in use
        phase_left <= '0;
        step_cnt   <= 8'h00;
      end
      else if (switch_event)
      begin
        phase_left <= phase_diff;
        step_cnt   <= 8'h00;
      end
      // one period stretched per step, never shortened
      else if (phase_left != '0)
      begin
        if (step_cnt == 8'(PSL_STEP_CYC - 1))
        begin
          step_cnt      <= 8'h00;
          phase_left    <= phase_left - 1'b1;
          stretch_pulse <= 1'b1;
        end
        else
          step_cnt <= step_cnt + 8'h01;
      end
    end
  end

  // control register writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl.mode    <= MODE_RESET;
      ctrl.policy  <= POLICY_RESET;
      ctrl.clk_sel <= SEL_RESET;
    end
    else if (psel && penable && pwrite && paddr == CTRL_ADDR)
    begin
      ctrl.mode    <= pwdata[MODE_LSB +: 2];
      ctrl.policy  <= pwdata[POLICY_LSB +: 2];
      ctrl.clk_sel <= pwdata[SEL_BIT];
    end
  end

  // apb answer, prepared in the setup cycle for a zero-wait access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= 1'b1;
      if (setup)
      begin
        prdata  <= 32'h0000_0000;
        pslverr <= 1'b0;
        if (paddr == CTRL_ADDR)
          prdata <= {27'h0, ctrl};
        else if (paddr == STATUS_ADDR)
        begin
          // status is read only; a write is answered with an error
          if (!pwrite)
            prdata <= {21'h0, state, free_run_flag, holdover_alarm, active_ref, pll_locked_flag,
                       ref1_missing_alarm, ref0_missing_alarm, crystal_missing_alarm};
          else
            pslverr <= 1'b1;
        end
        else
          pslverr <= 1'b1;
      end
    end
  end

endmodule

// ### test/ref_clock_monitor_switchover_monitor.sv
// checker for alarm, lock, holdover and phase slope behaviour at the block ports
`timescale 1ns/100ps
module ref_clock_monitor_switchover_monitor
  import clock_monitor_pkg::*;
(
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [7:0]               paddr,
  input wire logic [31:0]              pwdata,
  input wire logic                     pready,
  input wire clock_monitor_pkg::edge_s edges,
  input wire logic                     freq_lock,
  input wire logic                     crystal_missing_alarm,
  input wire logic                     ref0_missing_alarm,
  input wire logic                     ref1_missing_alarm,
  input wire logic                     pll_locked_flag,
  input wire logic                     active_ref,
  input wire logic                     holdover_alarm,
  input wire logic                     free_run_flag,
  input wire logic                     stretch_pulse
);
  logic [1:0] mode;
  logic [1:0] xc;
  logic [1:0] c0;
  logic [1:0] c1;
  logic       fb;
  function automatic logic [1:0] step(logic [1:0] c, logic seen, logic tick);
    return seen ? 2'h0 : (tick && c != MISS_EDGES) ? c + 2'h1 : c;
  endfunction
  assign fb = (mode == MODE_LBW) ? edges.lower_fb : edges.upper_fb;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode <= MODE_RESET;
    else if (psel && penable && pready && pwrite && paddr == CTRL_ADDR)
      mode <= pwdata[MODE_LSB +: 2];
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xc <= 2'h0;
      c0 <= 2'h0;
      c1 <= 2'h0;
    end
    else
    begin
      xc <= step(xc, edges.xtal, edges.upper_fb);
      c0 <= step(c0, edges.ref0, fb);
      c1 <= step(c1, edges.ref1, fb);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_XTAL_ALARM: assert property (crystal_missing_alarm == (xc == MISS_EDGES))
    else $error("crystal alarm off count");
  AST_REF0_ALARM: assert property (ref0_missing_alarm == (c0 == MISS_EDGES))
    else $error("ref0 alarm off count");
  AST_REF1_ALARM: assert property (ref1_missing_alarm == (c1 == MISS_EDGES))
    else $error("ref1 alarm off count");
  AST_LOCK_FALL: assert property ($fell(freq_lock) |=> !pll_locked_flag)
    else $error("lock flag kept after lock loss");
  AST_LOCK_HOLD: assert property (holdover_alarm && $past(holdover_alarm) |-> !pll_locked_flag)
    else $error("lock flag in holdover");
  AST_FREE_RUN: assert property (free_run_flag |-> holdover_alarm && $past(mode) == MODE_HBW)
    else $error("free run flag wrong");
  AST_NO_ADJ: assert property (holdover_alarm && $past(holdover_alarm) |-> !stretch_pulse)
    else $error("stretch in holdover");
  AST_STRETCH_RATE: assert property (stretch_pulse |=> !stretch_pulse [*7])
    else $error("stretch too frequent");
  AST_SYNTH: assert property (mode == MODE_SYNTH && $past(mode, 2) == MODE_SYNTH
    |-> !holdover_alarm && $stable(active_ref))
    else $error("switching in synthesizer mode");
  C_XTAL: cover property ($rose(crystal_missing_alarm));
  C_HOLD: cover property ($rose(holdover_alarm));
  C_STRETCH: cover property (stretch_pulse);
  C_SWITCH: cover property ($changed(active_ref));
endmodule

bind ref_clock_monitor_switchover ref_clock_monitor_switchover_monitor i_mon (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .edges, .freq_lock, .crystal_missing_alarm,
  .ref0_missing_alarm, .ref1_missing_alarm, .pll_locked_flag, .active_ref, .holdover_alarm,
  .free_run_flag, .stretch_pulse);

// ### test/ref_source_model.sv
// reference, crystal and feedback edge pulse source
`timescale 1ns/100ps
module ref_source_model
  import clock_monitor_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                en_xtal,
  input  wire logic                en_ref0,
  input  wire logic                en_ref1,
  input  wire logic                en_lower_fb,
  output clock_monitor_pkg::edge_s edges
);
  logic phase;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase <= 1'b0;
      edges <= '0;
    end
    else
    begin
      phase <= ~phase;
      edges <= '{xtal: en_xtal & phase, ref0: en_ref0 & phase, ref1: en_ref1 & phase,
                 upper_fb: ~phase, lower_fb: en_lower_fb & ~phase};
    end
  end
endmodule

// ### test/tb.sv
// testbench: apb accesses and clock source scenarios for the reference monitor
`timescale 1ns/100ps
module tb;
  import clock_monitor_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, clk_sel_pin, freq_lock, pready, pslverr;
  logic [7:0] paddr, phase_diff;
  logic [31:0] pwdata, prdata;
  logic en_xtal, en_ref0, en_ref1, en_lower_fb, stretch_pulse, free_run_flag;
  logic crystal_missing_alarm, ref0_missing_alarm, ref1_missing_alarm;
  logic pll_locked_flag, active_ref, holdover_alarm;
  edge_s edges;
  int failures, n_checks, n_str;
  localparam int FX = 0, F0 = 1, F1 = 2, FL = 3, FA = 4, FH = 5, FF = 6;
  wire [6:0] flags = {free_run_flag, holdover_alarm, active_ref, pll_locked_flag,
                      ref1_missing_alarm, ref0_missing_alarm, crystal_missing_alarm};
  ref_clock_monitor_switchover i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .edges, .clk_sel_pin, .freq_lock, .phase_diff, .crystal_missing_alarm,
    .ref0_missing_alarm, .ref1_missing_alarm, .pll_locked_flag, .active_ref, .holdover_alarm,
    .free_run_flag, .stretch_pulse);
  ref_source_model i_src (.pclk, .presetn, .en_xtal, .en_ref0, .en_ref1, .en_lower_fb, .edges);
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    chk(32'(pslverr), 32'(err));
    if (!wr)
      chk(prdata, d);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_flag(int i, logic v);
    int k;
    for (k = 0; k < 40 && flags[i] !== v; k++)
      @(posedge pclk);
    chk(32'(flags[i]), 32'(v));
  endtask
  task automatic stay(int i, logic v);
    repeat (20) @(posedge pclk);
    chk(32'(flags[i]), 32'(v));
  endtask
  always @(posedge pclk)
    if (stretch_pulse === 1'b1)
      n_str <= n_str + 1;
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    failures++;
    summarize();
  end
  initial
  begin
    int base;
    {presetn, psel, penable, pwrite, paddr, pwdata, clk_sel_pin} = '0;
    {freq_lock, en_xtal, en_ref0, en_ref1, en_lower_fb} = '1;
    phase_diff = 8'h02;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, CTRL_ADDR, 32'h2, 0);
    apb(0, 8'h08, 32'h0, 1);
    apb(1, STATUS_ADDR, 32'h0, 1);
    wait_flag(FL, 1);
    en_xtal <= 0;
    wait_flag(FX, 1);
    en_xtal <= 1;
    wait_flag(FX, 0);
    en_lower_fb <= 0;
    en_ref0 <= 0;
    stay(F0, 0);
    en_lower_fb <= 1;
    wait_flag(F0, 1);
    en_ref0 <= 1;
    wait_flag(F0, 0);
    en_ref1 <= 0;
    wait_flag(F1, 1);
    en_ref1 <= 1;
    wait_flag(F1, 0);
    clk_sel_pin <= 1;
    wait_flag(FA, 1);
    clk_sel_pin <= 0;
    wait_flag(FA, 0);
    freq_lock <= 0;
    wait_flag(FL, 0);
    freq_lock <= 1;
    apb(1, CTRL_ADDR, 32'h15, 0);
    apb(0, CTRL_ADDR, 32'h15, 0);
    wait_flag(FA, 1);
    en_ref1 <= 0;
    en_lower_fb <= 0;
    wait_flag(FH, 1);
    wait_flag(F1, 1);
    stay(FF, 1);
    en_ref1 <= 1;
    en_lower_fb <= 1;
    wait_flag(FH, 0);
    apb(1, CTRL_ADDR, 32'h0A, 0);
    wait_flag(FA, 0);
    stay(FL, 1);
    en_ref0 <= 0;
    wait_flag(FA, 1);
    stay(FH, 0);
    base = n_str;
    en_ref0 <= 1;
    wait_flag(FA, 0);
    stay(FA, 0);
    chk(32'(n_str - base), 32'h2);
    apb(1, CTRL_ADDR, 32'h0E, 0);
    clk_sel_pin <= 1;
    stay(FA, 0);
    en_ref0 <= 0;
    wait_flag(FA, 1);
    en_ref0 <= 1;
    stay(FA, 1);
    en_ref0 <= 0;
    en_ref1 <= 0;
    wait_flag(FH, 1);
    base = n_str;
    stay(FH, 1);
    chk(32'(n_str - base), 32'h0);
    en_ref1 <= 1;
    wait_flag(FH, 0);
    stay(FA, 1);
    en_ref1 <= 0;
    wait_flag(FH, 1);
    {en_ref0, en_ref1} <= 2'h3;
    wait_flag(FH, 0);
    stay(FA, 0);
    apb(1, CTRL_ADDR, 32'h0, 0);
    en_ref0 <= 0;
    en_ref1 <= 0;
    stay(FH, 0);
    apb(0, STATUS_ADDR, 32'h0000_008E, 0);
    freq_lock <= 0;
    en_ref1 <= 1;
    apb(1, CTRL_ADDR, 32'h0000_000A, 0);
    stay(FA, 0);
    stay(FH, 0);
    summarize();
  end
endmodule
